/* File: hdl/sss_device.sv */
// supply status register bank reached over the serial link
`timescale 1ns/100ps

module sss_device
	import sss_pkg::*;
#(
	parameter int          SHORT_CYC = SHORT_CYC_DEF,
	parameter logic [7:0]  ID_VALUE  = 8'h5A  // arbitrary identification value
)(
	input  wire logic      ref_clk,           // system clock
	input  wire logic      srst,              // power-on reset, sync, high
	sss_spi_if.dev         spi,               // serial link, device end
	input  wire sss_mode_e mode,              // current operating mode
	input  wire logic      soft_reset,        // soft reset command pulse
	input  wire logic      main_reg_on,       // main regulator enabled
	input  wire logic      charge_pump_enable,// charge pump enabled
	input  wire logic      load_peak_high,    // load above load_peak_threshold
	input  wire logic      reset_output_pin,  // reset output released (high)
	input  wire logic      sup_uv_det,        // battery_supply below uv level
	input  wire logic      sup_ov_det,        // battery_supply above ov level
	input  wire logic      main_ov_det,       // main_regulator_output overvoltage
	input  wire logic      main_warn_det,     // main output below prewarning level
	input  wire logic      main_below_rst,    // main output below reset threshold
	input  wire logic      aux_ot_det,        // aux regulator overtemperature
	input  wire logic      aux_uv_det,        // aux_regulator_output undervoltage
	output logic [7:0]     status_a,          // supply_fault_status_a contents
	output logic [7:0]     status_b           // supply_fault_status_b contents
);
	logic [1:0]  sclk_sync_ff, cs_sync_ff, mosi_sync_ff;
	logic        sclk_d_ff, cs_d_ff;
	logic        sclk_rise, sclk_fall, cs_rise, cs_fall, cs_act;
	logic [4:0]  bit_cnt_ff;
	logic [15:0] rx_ff;
	logic [7:0]  rd_ff;
	logic        miso_ff;
	logic [7:0]  sup_a_ff, sup_b_ff;
	logic [31:0] short_cnt_ff;
	logic        short_long;
	logic        frame_ok, clr_a, clr_b;
	logic [7:0]  set_a, set_b;
	logic        sleep_off, stop_exc, uv_en, ov_en, main_uv_upd;

	// link pins come from another clock; two stages before any use
	always_ff @(posedge ref_clk) begin
		sclk_sync_ff <= {sclk_sync_ff[0], spi.sclk};
		cs_sync_ff   <= {cs_sync_ff[0], spi.cs_n};
		mosi_sync_ff <= {mosi_sync_ff[0], spi.mosi};
		sclk_d_ff    <= sclk_sync_ff[1];
		cs_d_ff      <= cs_sync_ff[1];
	end

	assign cs_act    = ~cs_sync_ff[1];
	assign sclk_rise = sclk_sync_ff[1] & ~sclk_d_ff & cs_act;
	assign sclk_fall = ~sclk_sync_ff[1] & sclk_d_ff & cs_act;
	assign cs_rise   = cs_sync_ff[1] & ~cs_d_ff;
	assign cs_fall   = ~cs_sync_ff[1] & cs_d_ff;

	always_ff @(posedge ref_clk) begin
		if (srst || !cs_act) begin
			bit_cnt_ff <= 5'h00;
		end else if (sclk_rise && bit_cnt_ff < 5'(FRAME_BITS)) begin
			bit_cnt_ff <= bit_cnt_ff + 5'h01;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			rx_ff <= 16'h0000;
		end else if (sclk_rise && bit_cnt_ff < 5'(FRAME_BITS)) begin
			rx_ff[bit_cnt_ff[3:0]] <= mosi_sync_ff[1];
		end
	end

	function automatic logic [7:0] read_mux(input logic [6:0] a);
		logic [7:0] v;
		v = 8'h00;
		case (a)
			ADDR_SUP_A: v = sup_a_ff;
			ADDR_SUP_B: v = sup_b_ff;
			ADDR_ID:    v = ID_VALUE;
			// other status registers live outside this bank and read zero
			default:    v = 8'h00;
		endcase
		return v;
	endfunction

	// snapshot taken as the mode bit arrives, so a clear returns pre-clear data
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			rd_ff <= 8'h00;
		end else if (sclk_rise && bit_cnt_ff == 5'(MODE_BIT)) begin
			rd_ff <= read_mux(rx_ff[ADDR_BITS-1:0]);
		end
	end

	// data byte bit k leaves as frame bit 8+k
	always_ff @(posedge ref_clk) begin
		if (srst || cs_fall) begin
			miso_ff <= 1'b0;
		end else if (sclk_fall) begin
			if (bit_cnt_ff >= 5'(DATA_LSB) && bit_cnt_ff < 5'(FRAME_BITS)) begin
				miso_ff <= rd_ff[bit_cnt_ff[2:0]];
			end else begin
				miso_ff <= 1'b0;
			end
		end
	end

	assign spi.miso_o  = miso_ff;
	assign spi.miso_oe = cs_act;

	// only a full frame with the mode bit high clears; reads never do
	assign frame_ok = cs_rise && bit_cnt_ff == 5'(FRAME_BITS);
	// clear strobe for the addressed byte
	assign clr_a    = frame_ok && rx_ff[MODE_BIT] && rx_ff[6:0] == ADDR_SUP_A;
	assign clr_b    = frame_ok && rx_ff[MODE_BIT] && rx_ff[6:0] == ADDR_SUP_B;

	// low-output timer while the regulator is switched on
	always_ff @(posedge ref_clk) begin
		if (srst || !(main_reg_on && main_below_rst)) begin
			short_cnt_ff <= 32'h00000000;
		end else if (short_cnt_ff != 32'(SHORT_CYC)) begin
			short_cnt_ff <= short_cnt_ff + 32'h00000001;
		end
	end
	assign short_long = short_cnt_ff == 32'(SHORT_CYC);

	// sleep with the main regulator off
	assign sleep_off = mode == SSS_SLEEP && !main_reg_on;
	assign stop_exc  = load_peak_high || sup_a_ff[A_MAIN_WARN];
	// supply detection needs the main regulator
	assign uv_en     = main_reg_on && (mode != SSS_STOP || stop_exc);
	// charge pump keeps overvoltage detection alive
	assign ov_en     = main_reg_on && (charge_pump_enable || mode != SSS_STOP || stop_exc);

	always_comb begin
		case (mode)
			SSS_NORMAL, SSS_STOP: main_uv_upd = 1'b1;
			SSS_INIT:             main_uv_upd = reset_output_pin;
			SSS_RESTART:          main_uv_upd = 1'b0;
			default:              main_uv_upd = !sleep_off;
		endcase
		if (short_long && !sleep_off) begin
			main_uv_upd = 1'b1;
		end
	end

	always_comb begin
		set_a              = 8'h00;
		set_a[A_SUP_UV]    = sup_uv_det && uv_en;
		set_a[A_SUP_OV]    = sup_ov_det && ov_en;
		set_a[A_MAIN_OV]   = main_ov_det && !sleep_off;
		set_a[A_MAIN_WARN] = main_warn_det;
	end

	always_comb begin
		set_b            = 8'h00;
		set_b[B_AUX_OT]  = aux_ot_det;
		set_b[B_AUX_UV]  = aux_uv_det;
		set_b[B_MAIN_SC] = short_long && !sleep_off;
		set_b[B_MAIN_UV] = main_below_rst && main_uv_upd;
	end

	// sticky flags; reserved bits masked off
	always_ff @(posedge ref_clk) begin
		if (srst || soft_reset) begin
			sup_a_ff <= A_RST;
		end else begin
			// set term applied after the clear
			sup_a_ff <= ((sup_a_ff & ~(clr_a ? A_RC_MASK : 8'h00)) | set_a) & A_RC_MASK;
		end
	end

	// power-on leaves the por bit set, soft reset does not
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			sup_b_ff <= B_RST_POR;
		end else if (soft_reset) begin
			sup_b_ff <= B_RST_SOFT;
		end else begin
			// set term applied after the clear
			sup_b_ff <= ((sup_b_ff & ~(clr_b ? B_RC_MASK : 8'h00)) | set_b) & B_RC_MASK;
		end
	end

	assign status_a = sup_a_ff;
	assign status_b = sup_b_ff;
endmodule

/* File: hdl/sss_pkg.sv */
// shared constants and types for the supply status register bank and its host
package sss_pkg;
	// device operating modes as seen by the flag gating
	typedef enum logic [2:0] {
		SSS_INIT, SSS_NORMAL, SSS_STOP, SSS_SLEEP, SSS_RESTART, SSS_FAILSAFE
	} sss_mode_e;

	// frame layout, frame bit 0 travels first
	localparam int         FRAME_BITS   = 16;
	localparam int         ADDR_BITS    = 7;
	localparam int         MODE_BIT     = 7;
	localparam int         DATA_LSB     = 8;

	// status register addresses
	localparam logic [6:0] ADDR_SUP_A   = 7'h40;
	localparam logic [6:0] ADDR_SUP_B   = 7'h41;
	localparam logic [6:0] ADDR_THERM   = 7'h42;
	localparam logic [6:0] ADDR_DEV     = 7'h43;
	localparam logic [6:0] ADDR_BUS     = 7'h44;
	localparam logic [6:0] ADDR_WAKE_A  = 7'h46;
	localparam logic [6:0] ADDR_WAKE_B  = 7'h47;
	localparam logic [6:0] ADDR_WAKE_L  = 7'h48;
	localparam logic [6:0] ADDR_PORT_OC = 7'h54;
	localparam logic [6:0] ADDR_PORT_OL = 7'h55;
	localparam logic [6:0] ADDR_SWK     = 7'h70;
	localparam logic [6:0] ADDR_SWK_EC  = 7'h71;
	localparam logic [6:0] ADDR_CDR_A   = 7'h72;
	localparam logic [6:0] ADDR_CDR_B   = 7'h73;
	localparam logic [6:0] ADDR_ID      = 7'h7E;

	// supply_fault_status_a fields
	localparam int         A_SUP_UV     = 6;
	localparam int         A_SUP_OV     = 5;
	localparam int         A_MAIN_OV    = 1;
	localparam int         A_MAIN_WARN  = 0;
	localparam logic [7:0] A_RC_MASK    = 8'h63;
	localparam logic [7:0] A_RST        = 8'h00;

	// supply_fault_status_b fields
	localparam int         B_POR        = 7;
	localparam int         B_AUX_OT     = 4;
	localparam int         B_AUX_UV     = 3;
	localparam int         B_MAIN_SC    = 2;
	localparam int         B_MAIN_UV    = 0;
	localparam logic [7:0] B_RC_MASK    = 8'h9D;
	localparam logic [7:0] B_RST_POR    = 8'h80;
	localparam logic [7:0] B_RST_SOFT   = 8'h00;

	// timing
	localparam int         CLK_PERIOD_NS = 10;
	localparam int         SHORT_TIME_US = 2000;
	localparam int         SHORT_CYC_DEF = (SHORT_TIME_US * 1000) / CLK_PERIOD_NS;
	localparam int         SCLK_HALF_CYC = 4;
	localparam int         CS_GAP_CYC    = 8;

	// host controller register map (APB byte addresses)
	localparam logic [7:0] H_CMD        = 8'h00;
	localparam logic [7:0] H_STATUS     = 8'h04;
	localparam logic [7:0] H_INT_STAT   = 8'h08;
	localparam logic [7:0] H_INT_MASK   = 8'h0C;
	localparam int         CMD_CLR_BIT  = 7;
	localparam int         ST_BUSY_BIT  = 0;
	localparam int         ST_DATA_LSB  = 8;
	localparam int         INT_DONE     = 0;
	localparam int         INT_DROP     = 1;
	localparam logic [1:0] INT_RST      = 2'h0;
endpackage

/* File: hdl/sss_spi_if.sv */
// four-wire serial link between the host controller and the status bank
`timescale 1ns/100ps
interface sss_spi_if;
	logic sclk;
	logic cs_n;
	logic mosi;
	logic miso_o;
	logic miso_oe;
	logic miso;

	// an undriven return line reads low
	assign miso = miso_oe ? miso_o : 1'b0;

	modport host (output sclk, output cs_n, output mosi, input miso);
	modport dev  (input sclk, input cs_n, input mosi, output miso_o, output miso_oe);
endinterface

/* File: hdl/sss_host.sv */
// host-side link controller driven by software over apb
`timescale 1ns/100ps
module sss_host
	import sss_pkg::*;
(
	input  wire logic        ref_clk,  // system clock
	input  wire logic        srst,     // sync reset, high
	input  wire logic        psel,     // apb select
	input  wire logic        penable,  // apb access phase
	input  wire logic        pwrite,   // apb write
	input  wire logic [7:0]  paddr,    // apb byte address
	input  wire logic [31:0] pwdata,   // apb write data
	output logic             pready,   // apb ready
	output logic [31:0]      prdata,   // apb read data
	output logic             pslverr,  // apb error, unmapped address
	output logic             irq,      // level interrupt
	sss_spi_if.host          spi       // serial link, host end
);
	typedef enum {ST_IDLE, ST_SETUP, ST_HIGH, ST_LOW, ST_HOLD, ST_GAP} sss_hstate_e;

	sss_hstate_e state_ff;
	logic [3:0]  div_ff;
	logic [4:0]  bit_ff;
	logic [15:0] tx_ff;
	logic [7:0]  rx_ff;
	logic [1:0]  miso_sync_ff;
	logic        sclk_ff, cs_n_ff, mosi_ff;
	logic        pready_ff, pslverr_ff;
	logic [31:0] prdata_ff;
	logic [1:0]  int_stat_ff, int_mask_ff, int_set;
	logic        wr_acc, cmd_wr, start, done, div_end;

	assign wr_acc  = psel && penable && pready_ff && pwrite;
	assign cmd_wr  = wr_acc && paddr == H_CMD;
	assign start   = cmd_wr && state_ff == ST_IDLE;
	assign div_end = div_ff == 4'(SCLK_HALF_CYC - 1);
	assign done    = state_ff == ST_HOLD && div_end;
	assign int_set = {cmd_wr && state_ff != ST_IDLE, done};

	// one wait state: answer registered one cycle into the access phase
	always_ff @(posedge ref_clk) begin
		if (srst || pready_ff || !(psel && penable)) begin
			pready_ff  <= 1'b0;
			pslverr_ff <= 1'b0;
			prdata_ff  <= 32'h00000000;
		end else begin
			pready_ff  <= 1'b1;
			pslverr_ff <= !(paddr == H_CMD || paddr == H_STATUS ||
				paddr == H_INT_STAT || paddr == H_INT_MASK);
			case (paddr)
				H_STATUS:   prdata_ff <= {16'h0000, rx_ff, 7'h00, state_ff != ST_IDLE};
				H_INT_STAT: prdata_ff <= {30'h00000000, int_stat_ff};
				H_INT_MASK: prdata_ff <= {30'h00000000, int_mask_ff};
				default:    prdata_ff <= 32'h00000000;
			endcase
		end
	end

	assign pready  = pready_ff;
	assign pslverr = pslverr_ff;
	assign prdata  = prdata_ff;

	// set wins over a write-one clear in the same cycle
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			int_stat_ff <= INT_RST;
		end else if (wr_acc && paddr == H_INT_STAT) begin
			int_stat_ff <= (int_stat_ff & ~pwdata[1:0]) | int_set;
		end else begin
			int_stat_ff <= int_stat_ff | int_set;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			int_mask_ff <= INT_RST;
		end else if (wr_acc && paddr == H_INT_MASK) begin
			int_mask_ff <= pwdata[1:0];
		end
	end

	assign irq = |(int_stat_ff & int_mask_ff);

	always_ff @(posedge ref_clk) begin
		miso_sync_ff <= {miso_sync_ff[0], spi.miso};
	end

	// frame sequencer; link clock from a divider of ref_clk
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			state_ff <= ST_IDLE;
			div_ff   <= 4'h0;
			bit_ff   <= 5'h00;
			tx_ff    <= 16'h0000;
			rx_ff    <= 8'h00;
			sclk_ff  <= 1'b0;
			cs_n_ff  <= 1'b1;
			mosi_ff  <= 1'b0;
		end else begin
			div_ff <= div_end ? 4'h0 : div_ff + 4'h1;
			case (state_ff)
				ST_IDLE: begin
					div_ff <= 4'h0;
					if (start) begin
						tx_ff    <= {8'h00, pwdata[CMD_CLR_BIT], pwdata[6:0]};
						mosi_ff  <= pwdata[0];
						cs_n_ff  <= 1'b0;
						bit_ff   <= 5'h00;
						state_ff <= ST_SETUP;
					end
				end
				ST_SETUP, ST_LOW: begin
					if (div_end) begin
						sclk_ff  <= 1'b1;
						state_ff <= ST_HIGH;
					end
				end
				ST_HIGH: begin
					if (div_end) begin
						sclk_ff <= 1'b0;
						// data byte returns in frame bits 8..15
						if (bit_ff >= 5'(DATA_LSB)) begin
							rx_ff[bit_ff[2:0]] <= miso_sync_ff[1];
						end
						bit_ff <= bit_ff + 5'h01;
						if (bit_ff == 5'(FRAME_BITS - 1)) begin
							state_ff <= ST_HOLD;
						end else begin
							mosi_ff  <= tx_ff[4'(bit_ff + 5'h01)];
							state_ff <= ST_LOW;
						end
					end
				end
				ST_HOLD: begin
					if (div_end) begin
						cs_n_ff  <= 1'b1;
						mosi_ff  <= 1'b0;
						// gap count restarts at zero, else it wraps through 31 and stalls commands
						bit_ff   <= 5'h00;
						state_ff <= ST_GAP;
					end
				end
				ST_GAP: begin
					div_ff <= bit_ff == 5'h00 ? div_ff : 4'h0;
					bit_ff <= bit_ff == 5'(CS_GAP_CYC) ? 5'h00 : bit_ff + 5'h01;
					if (bit_ff == 5'(CS_GAP_CYC)) begin
						state_ff <= ST_IDLE;
					end
				end
				default: state_ff <= ST_IDLE;
			endcase
		end
	end

	assign spi.sclk = sclk_ff;
	assign spi.cs_n = cs_n_ff;
	assign spi.mosi = mosi_ff;
endmodule

/* File: tb/sss_link_checker.sv */
// link protocol assertions for the serial link between host and status bank
`timescale 1ns/100ps
module sss_link_checker (
	input  wire logic ref_clk, // system clock
	input  wire logic srst,    // sync reset, high
	input  wire logic sclk,    // link clock
	input  wire logic cs_n,    // frame select
	input  wire logic mosi,    // host data
	input  wire logic miso_o,  // device data
	input  wire logic miso_oe, // device drive enable
	input  wire logic miso     // resolved return line
);
	logic       sclk_q_ff;
	logic [4:0] rises_ff;

	default clocking @(posedge ref_clk); endclocking
	default disable iff (srst);

	always_ff @(posedge ref_clk) begin
		sclk_q_ff <= sclk;
	end

	// rising link edges seen so far in the open frame
	always_ff @(posedge ref_clk) begin
		if (srst || cs_n) begin
			rises_ff <= 5'h0;
		end else if (sclk && !sclk_q_ff) begin
			rises_ff <= rises_ff + 5'h1;
		end
	end

	AST_SCLK_IDLE: assert property (cs_n |-> !sclk)
		else $error("link clock runs outside a frame");
	AST_SCLK_HIGH: assert property ($rose(sclk) |-> sclk[*4] ##1 !sclk)
		else $error("link clock high half not four cycles");
	AST_SCLK_LOW: assert property ($fell(sclk) |-> !sclk[*4])
		else $error("link clock low half too short");
	AST_CS_TAIL: assert property ($fell(sclk) |-> !cs_n[*3])
		else $error("frame select released too soon");
	AST_CS_GAP: assert property ($rose(cs_n) |-> cs_n[*8])
		else $error("gap between frames too short");
	AST_FRAME_LEN: assert property ($rose(cs_n) |-> rises_ff == 5'h10)
		else $error("frame does not hold sixteen bits");
	AST_MOSI_HOLD: assert property (sclk |-> $stable(mosi))
		else $error("host data moved while link clock high");
	AST_ADDR_QUIET: assert property (!cs_n && rises_ff < 5'h8 |-> !miso)
		else $error("device drove data during address byte");
	AST_OE_ON: assert property ($fell(cs_n) |-> ##[1:4] miso_oe)
		else $error("device did not take the return line");
	AST_OE_OFF: assert property (cs_n[*4] |-> !miso_oe)
		else $error("device holds return line outside a frame");
	AST_RET_WIRE: assert property (miso_oe |-> miso == miso_o)
		else $error("return line does not carry device data");
endmodule

/* File: tb/spi_supply_status_flags_tb.sv */
// self-checking bench: host controller and status bank joined over the link
`timescale 1ns/100ps
module spi_supply_status_flags_tb;
	import sss_pkg::*;
	typedef struct {logic [7:0] a; logic [31:0] m; logic [31:0] v; logic e;} sss_note_s;
	logic        ref_clk, srst, psel, penable, pwrite, pready, pslverr, irq, p;
	logic        soft_reset, main_reg_on, charge_pump_enable, load_peak_high, reset_output_pin;
	logic [7:0]  paddr, status_a, status_b, ea, eb;
	logic [31:0] pwdata, prdata, r;
	logic [6:0]  ev; // sup uv, sup ov, main ov, warn, below reset, aux ot, aux uv
	logic [6:0]  hit; // events held across the edge where a clear lands
	sss_mode_e   mode;
	int          n_errors, checked;
	sss_note_s   q[$];
	sss_note_s   n;
	sss_spi_if   spi();

	sss_device #(.SHORT_CYC(20)) sss_device_i (.ref_clk, .srst, .spi(spi.dev), .mode,
		.soft_reset, .main_reg_on, .charge_pump_enable, .load_peak_high, .reset_output_pin,
		.sup_uv_det(ev[0]), .sup_ov_det(ev[1]), .main_ov_det(ev[2]), .main_warn_det(ev[3]),
		.main_below_rst(ev[4]), .aux_ot_det(ev[5]), .aux_uv_det(ev[6]), .status_a, .status_b);
	sss_host sss_host_i (.ref_clk, .srst, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
		.prdata, .pslverr, .irq, .spi(spi.host));
	sss_link_checker sss_link_checker_i (.ref_clk, .srst, .sclk(spi.sclk), .cs_n(spi.cs_n),
		.mosi(spi.mosi), .miso_o(spi.miso_o), .miso_oe(spi.miso_oe), .miso(spi.miso));

	initial begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end

	task automatic print_verdict();
		$display("comparisons %0d mismatches %0d", checked, n_errors);
		if (n_errors == 0 && checked > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
		checked++;
		if (g !== e)
			$display("mismatch %s expected %h seen %h", s, e, g);
		if (g !== e)
			n_errors++;
	endtask

	// one apb transfer; the note lets the monitor judge the answer
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
		input logic [31:0] m, input logic [31:0] v, input logic e);
		int k;
		@(posedge ref_clk);
		q.push_back('{a, m, v & m, e});
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge ref_clk);
		penable <= 1'b1;
		k = 0;
		do begin
			@(posedge ref_clk);
			k++;
		end while (pready !== 1'b1 && k < 50);
		if (k >= 50) begin
			$display("mismatch pready expected 1 seen 0");
			n_errors++;
			print_verdict();
		end
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	always @(posedge ref_clk) begin
		if (psel && penable && pready === 1'b1) begin
			if (q.size() == 0)
				n = '{8'h0, 32'h0, 32'h1, 1'b0};
			else
				n = q.pop_front();
			chk($sformatf("apb %h data", n.a), n.v, prdata & n.m);
			chk($sformatf("apb %h error", n.a), {31'h0, n.e}, {31'h0, pslverr});
		end
	end

	// a link frame through the host; done is the only unmasked interrupt
	task automatic frame(input logic [6:0] a, input logic c, input logic [7:0] d);
		int k;
		apb(1'b1, H_CMD, {24'h0, c, a}, 32'h0, 32'h0, 1'b0);
		k = 0;
		while (irq !== 1'b1 && k < 3000) begin
			@(posedge ref_clk);
			k++;
		end
		if (k >= 3000) begin
			$display("mismatch irq expected 1 seen 0");
			n_errors++;
			print_verdict();
		end
		// the device applies a clear three edges after cs_n rises; hit spans that edge
		ev <= hit;
		repeat (2) @(posedge ref_clk);
		ev <= 7'h00;
		apb(1'b0, H_STATUS, 32'h0, 32'hFF00, {16'h0, d, 8'h0}, 1'b0);
		apb(1'b1, H_INT_STAT, 32'h1, 32'h0, 32'h0, 1'b0);
		repeat (12) @(posedge ref_clk);
	endtask

	task automatic pulse(input logic [6:0] e, input int len);
		ev <= e;
		repeat (len) @(posedge ref_clk);
		ev <= 7'h0;
		repeat (3) @(posedge ref_clk);
	endtask

	initial begin
		{psel, penable, pwrite, paddr, pwdata, ev, hit} = '0;
		{soft_reset, charge_pump_enable, load_peak_high, reset_output_pin} = '0;
		main_reg_on = 1'b1;
		mode = SSS_NORMAL;
		srst = 1'b1;
		n_errors = 0;
		checked = 0;
		r = $urandom(32'h78C4);
		repeat (20) @(posedge ref_clk);
		srst <= 1'b0;
		chk("status_a", {24'h0, A_RST}, {24'h0, status_a});
		chk("status_b", {24'h0, B_RST_POR}, {24'h0, status_b});
		apb(1'b0, H_INT_MASK, 32'h0, 32'h3, 32'h0, 1'b0);
		apb(1'b0, 8'h10, 32'h0, 32'hFFFF_FFFF, 32'h0, 1'b1);
		apb(1'b1, 8'h10, 32'h1, 32'h0, 32'h0, 1'b1);
		apb(1'b1, H_INT_MASK, 32'h1, 32'h0, 32'h0, 1'b0);
		frame(ADDR_ID, 1'b0, 8'h5A);
		frame(ADDR_THERM, 1'b1, 8'h00);
		// this command starts a frame; the ADDR_SUP_A one lands while busy and must be dropped, masked interrupt
		apb(1'b1, H_CMD, {25'h0, ADDR_ID}, 32'h0, 32'h0, 1'b0);
		frame(ADDR_SUP_A, 1'b0, 8'h5A);
		apb(1'b0, H_INT_STAT, 32'h0, 32'h3, 32'h2, 1'b0);
		chk("irq masked", 32'h0, {31'h0, irq});
		apb(1'b1, H_INT_STAT, 32'h2, 32'h0, 32'h0, 1'b0);
		apb(1'b0, H_INT_STAT, 32'h0, 32'h3, 32'h0, 1'b0);
		p = 1'b1;
		repeat (5) begin
			r = $urandom;
			pulse(r[6:0], 1);
			ea = {1'b0, r[0], r[1], 3'h0, r[2], r[3]};
			eb = {p, 2'h0, r[5], r[6], 2'h0, r[4]};
			frame(ADDR_SUP_A, 1'b0, ea);
			chk("status_a kept", {24'h0, ea}, {24'h0, status_a});
			frame(ADDR_SUP_A, 1'b1, ea);
			frame(ADDR_SUP_B, 1'b1, eb);
			chk("status_a cleared", 32'h0, {24'h0, status_a});
			chk("status_b cleared", 32'h0, {24'h0, status_b});
			p = 1'b0;
		end
		main_reg_on <= 1'b0;
		pulse(7'h03, 1);
		chk("supply off", 32'h0, {24'h0, status_a});
		main_reg_on <= 1'b1;
		mode <= SSS_STOP;
		pulse(7'h03, 1);
		chk("stop gated", 32'h0, {24'h0, status_a});
		charge_pump_enable <= 1'b1;
		pulse(7'h03, 1);
		chk("stop pump", 32'h20, {24'h0, status_a});
		load_peak_high <= 1'b1;
		pulse(7'h01, 1);
		chk("stop peak", 32'h60, {24'h0, status_a});
		main_reg_on <= 1'b0;
		mode <= SSS_SLEEP;
		pulse(7'h14, 3);
		chk("sleep a", 32'h60, {24'h0, status_a});
		chk("sleep b", 32'h0, {24'h0, status_b});
		main_reg_on <= 1'b1;
		mode <= SSS_RESTART;
		pulse(7'h10, 1);
		chk("restart uv", 32'h0, {24'h0, status_b});
		mode <= SSS_INIT;
		pulse(7'h10, 1);
		chk("init held", 32'h0, {24'h0, status_b});
		reset_output_pin <= 1'b1;
		pulse(7'h10, 1);
		chk("init released", 32'h1, {24'h0, status_b});
		mode <= SSS_NORMAL;
		pulse(7'h10, 10);
		chk("short early", 32'h1, {24'h0, status_b});
		pulse(7'h10, 25);
		chk("short set", 32'h5, {24'h0, status_b});
		hit <= 7'h08;
		frame(ADDR_SUP_A, 1'b1, 8'h60);
		hit <= 7'h00;
		chk("clear vs event", 32'h1, {24'h0, status_a});
		soft_reset <= 1'b1;
		@(posedge ref_clk);
		soft_reset <= 1'b0;
		repeat (2) @(posedge ref_clk);
		chk("soft a", 32'h0, {24'h0, status_a});
		chk("soft b", {24'h0, B_RST_SOFT}, {24'h0, status_b});
		print_verdict();
	end
endmodule
